// [common/acr_pkg.sv]
package acr_pkg;

    // ---------------------------------------------------------------
    // Register map (word aligned byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL0_ON_BIT = 0;
    localparam int CTRL0_GO_BIT = 1;
    localparam int CTRL0_SEL_LSB = 2;
    localparam int CTRL1_REF_BIT = 0;
    localparam int CTRL1_CLK_LSB = 4;
    localparam int IRQ_DONE_BIT = 0;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // ---------------------------------------------------------------
    // Conversion clock codes and divisors
    // ---------------------------------------------------------------
    localparam logic [2:0] CLK_DIV8 = 3'h1;
    localparam logic [2:0] CLK_DIV32 = 3'h2;
    localparam logic [2:0] CLK_DIV16 = 3'h5;
    localparam logic [2:0] CLK_DIV64 = 3'h6;
    localparam logic [6:0] DIV_8 = 7'h08;
    localparam logic [6:0] DIV_16 = 7'h10;
    localparam logic [6:0] DIV_32 = 7'h20;
    localparam logic [6:0] DIV_64 = 7'h40;
    localparam logic [6:0] DIV_RC = 7'h10;
    localparam logic [6:0] DIV_NONE = 7'h00;

    // Conversion takes this many conversion clock periods
    localparam logic [4:0] CONV_TICKS = 5'h0b;
    localparam int RES_BITS = 10;

    typedef struct packed {
        logic [4:0] input_select;
        logic conv_busy;
        logic converter_on;
    } acr_ctrl0_t;

    typedef struct packed {
        logic [2:0] conv_clock_select;
        logic reference_select;
    } acr_ctrl1_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT
    } acr_state_t;

endpackage : acr_pkg

// [src/acr_adc_regs.sv]
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module acr_adc_regs
    import acr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Internal RC oscillator tick, one pulse per RC period
    input wire logic rc_tick_i,
    // Analog front end
    input wire logic [9:0] conv_data_i,
    output logic [4:0] input_select_o,
    output logic reference_select_o,
    output logic converter_on_o,
    output logic sample_hold_o,
    output logic conv_strobe_o,
    // Interrupt
    output logic irq_o
);

    // ---------------------------------------------------------------
    // Clock divisor selection
    // ---------------------------------------------------------------
    function automatic logic [6:0] clk_divisor(input logic [2:0] code);
        logic [6:0] div;
        div = DIV_NONE;
        if (code[1:0] == 2'b11) begin
            div = DIV_RC;
        end else if (code == CLK_DIV8) begin
            div = DIV_8;
        end else if (code == CLK_DIV32) begin
            div = DIV_32;
        end else if (code == CLK_DIV16) begin
            div = DIV_16;
        end else if (code == CLK_DIV64) begin
            div = DIV_64;
        end
        return div;
    endfunction : clk_divisor

    acr_ctrl0_t ctrl0, next_ctrl0;
    acr_ctrl1_t ctrl1, next_ctrl1;
    acr_state_t state, next_state;
    logic [9:0] result, next_result;
    logic irq_status, next_irq_status;
    logic irq_mask, next_irq_mask;
    logic [6:0] div_cnt, next_div_cnt;
    logic [4:0] tick_cnt, next_tick_cnt;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic rc_meta, rc_sync, rc_prev;

    logic req;
    logic wr_lane0;
    logic [7:0] wbyte;
    logic [6:0] divisor;
    logic src_tick;
    logic conv_tick;
    logic done;

    assign req = wb_cyc_i && wb_stb_i && !ack;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign divisor = clk_divisor(ctrl1.conv_clock_select);
    assign src_tick = (ctrl1.conv_clock_select[1:0] == 2'b11) ? (rc_sync && !rc_prev) : 1'b1;

    // ---------------------------------------------------------------
    // RC tick synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rc_meta <= 1'b0;
            rc_sync <= 1'b0;
            rc_prev <= 1'b0;
        end else begin
            rc_meta <= rc_tick_i;
            rc_sync <= rc_meta;
            rc_prev <= rc_sync;
        end
    end

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_div_cnt = div_cnt;
        next_tick_cnt = tick_cnt;
        next_result = result;
        conv_tick = 1'b0;
        done = 1'b0;
        case (state)
            ST_IDLE: begin
                next_div_cnt = 7'h00;
                next_tick_cnt = 5'h00;
                if (ctrl0.conv_busy && ctrl0.converter_on && divisor != DIV_NONE) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (!ctrl0.converter_on) begin
                    next_state = ST_IDLE;
                end else if (src_tick) begin
                    if (div_cnt == divisor - 7'h01) begin
                        next_div_cnt = 7'h00;
                        conv_tick = 1'b1;
                    end else begin
                        next_div_cnt = div_cnt + 7'h01;
                    end
                end
                if (ctrl0.converter_on && conv_tick) begin
                    if (tick_cnt == CONV_TICKS - 5'h01) begin
                        next_result = conv_data_i;
                        done = 1'b1;
                        next_state = ST_IDLE;
                    end else begin
                        next_tick_cnt = tick_cnt + 5'h01;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            div_cnt <= 7'h00;
            tick_cnt <= 5'h00;
            result <= RESULT_RESET;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            tick_cnt <= next_tick_cnt;
            result <= next_result;
        end
    end

    // ---------------------------------------------------------------
    // Register file and Wishbone slave
    // ---------------------------------------------------------------
    always_comb begin
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        next_ack = req;
        next_rdata = 32'h0000_0000;
        if (wr_lane0) begin
            if (wb_adr_i == ADDR_CTRL0) begin
                next_ctrl0.input_select = wbyte[CTRL0_SEL_LSB +: 5];
                next_ctrl0.converter_on = wbyte[CTRL0_ON_BIT];
                next_ctrl0.conv_busy = wbyte[CTRL0_GO_BIT] && wbyte[CTRL0_ON_BIT];
            end else if (wb_adr_i == ADDR_CTRL1) begin
                next_ctrl1.conv_clock_select = wbyte[CTRL1_CLK_LSB +: 3];
                next_ctrl1.reference_select = wbyte[CTRL1_REF_BIT];
            end else if (wb_adr_i == ADDR_IRQ_STATUS) begin
                next_irq_status = irq_status && !wbyte[IRQ_DONE_BIT];
            end else if (wb_adr_i == ADDR_IRQ_MASK) begin
                next_irq_mask = wbyte[IRQ_DONE_BIT];
            end
        end
        if (done) begin
            next_ctrl0.conv_busy = 1'b0;
            next_irq_status = 1'b1;
        end else if (state == ST_CONVERT && !ctrl0.converter_on) begin
            next_ctrl0.conv_busy = 1'b0;
        end
        if (req && !wb_we_i) begin
            if (wb_adr_i == ADDR_CTRL0) begin
                next_rdata[7:0] = {1'b0, ctrl0.input_select, ctrl0.conv_busy, ctrl0.converter_on};
            end else if (wb_adr_i == ADDR_CTRL1) begin
                next_rdata[7:0] = {1'b0, ctrl1.conv_clock_select, 3'h0, ctrl1.reference_select};
            end else if (wb_adr_i == ADDR_RES_HIGH) begin
                next_rdata[7:0] = {6'h00, result[9:8]};
            end else if (wb_adr_i == ADDR_RES_LOW) begin
                next_rdata[7:0] = result[7:0];
            end else if (wb_adr_i == ADDR_IRQ_STATUS) begin
                next_rdata[7:0] = {7'h00, irq_status};
            end else if (wb_adr_i == ADDR_IRQ_MASK) begin
                next_rdata[7:0] = {7'h00, irq_mask};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl0 <= CTRL0_RESET[6:0];
            ctrl1 <= CTRL1_RESET[3:0];
            irq_status <= 1'b0;
            irq_mask <= 1'b0;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign input_select_o = ctrl0.input_select;
    assign reference_select_o = ctrl1.reference_select;
    assign converter_on_o = ctrl0.converter_on;
    // Hold marks the conversion window only; nothing discharges the capacitor afterwards
    assign sample_hold_o = (state == ST_CONVERT);
    assign conv_strobe_o = conv_tick;
    assign irq_o = irq_status && irq_mask;

endmodule : acr_adc_regs
`default_nettype wire

// [tb/acr_adc_regs_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module acr_adc_regs_checker
    import acr_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Converter side
    input wire logic [4:0] input_select_o,
    input wire logic reference_select_o,
    input wire logic converter_on_o,
    input wire logic sample_hold_o,
    input wire logic conv_strobe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(logic [7:0] a);
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence
    a_ack_after_req: assert property (s_req |=> wb_ack_o) else $error("ack missing");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    a_high_upper_zero: assert property (s_rd(ADDR_RES_HIGH) |-> wb_dat_o[31:2] == 30'h0)
        else $error("high result upper bits set");
    a_ctrl1_unused_zero: assert property (s_rd(ADDR_CTRL1) |-> wb_dat_o[31:7] == 25'h0 && wb_dat_o[3:1] == 3'h0)
        else $error("unused clock bits set");
    a_ref_follows_write: assert property (s_wr(ADDR_CTRL1) |=> reference_select_o == $past(wb_dat_i[0]))
        else $error("reference output wrong");
    a_select_follows_write: assert property (s_wr(ADDR_CTRL0) |=> input_select_o == $past(wb_dat_i[6:2]))
        else $error("input select wrong");
    a_strobe_while_hold: assert property (conv_strobe_o |-> sample_hold_o && converter_on_o)
        else $error("strobe outside conversion");
    a_off_no_hold: assert property (!converter_on_o && $past(!converter_on_o) |-> !sample_hold_o)
        else $error("converting while off");
    a_strobe_spacing: assert property (conv_strobe_o |=> !conv_strobe_o [*7])
        else $error("strobes too close");
endmodule : acr_adc_regs_checker
bind acr_adc_regs acr_adc_regs_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .input_select_o(input_select_o),
    .reference_select_o(reference_select_o), .converter_on_o(converter_on_o),
    .sample_hold_o(sample_hold_o), .conv_strobe_o(conv_strobe_o));
`default_nettype wire

// [tb/acr_adc_regs_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module acr_adc_regs_tb_top;
    import acr_pkg::*;
    logic clk_i, rst_n_i, cyc, we, ack, hold, strobe, irq, on, ref_o;
    logic [1:0] rcc;
    logic [7:0] adr;
    logic [31:0] wdat, dat_o, rdat;
    logic [4:0] sel_o;
    logic [9:0] data;
    int mismatches, n_compared, cnt;
    // Acquisition wait in 8 ns cycles: settling, hold charging, temperature term
    localparam int ACQ_SETTLE = 250;
    localparam int ACQ_CHARGE = 172;
    localparam int ACQ_TEMP = 157;
    localparam int ACQ_CYCLES = ACQ_SETTLE + ACQ_CHARGE + ACQ_TEMP;
    logic [2:0] codes [8] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h3, 3'h7, 3'h0, 3'h4};
    int divs [8] = '{8, 32, 16, 64, 16 * 4, 16 * 4, 0, 0};
    logic [9:0] vals [8] = '{10'h2a5, 10'h3ff, 10'h000, 10'h155, 10'h17e, 10'h201, 10'h0, 10'h0};
    acr_adc_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rc_tick_i(rcc[1]),
        .conv_data_i(data), .input_select_o(sel_o), .reference_select_o(ref_o), .converter_on_o(on),
        .sample_hold_o(hold), .conv_strobe_o(strobe), .irq_o(irq));
    task automatic complete_run;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin mismatches++; complete_run(); end
        rdat = dat_o;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wait_strobe;
        cnt = 0;
        do begin @(posedge clk_i); cnt++; end while (strobe !== 1'b1 && cnt < 1500);
    endtask : wait_strobe
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) rcc <= rcc + 2'h1;
    initial begin
        rst_n_i = 1'b0;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        data = 10'h000;
        rcc = 2'h0;
        mismatches = 0;
        n_compared = 0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        bus(1'b0, ADDR_CTRL1, 32'h0);
        check(rdat, 32'h0);
        bus(1'b1, ADDR_CTRL1, 32'hff);
        bus(1'b0, ADDR_CTRL1, 32'h0);
        check(rdat, 32'h71);
        bus(1'b0, 8'h20, 32'h0);
        check(rdat, 32'h0);
        bus(1'b1, ADDR_IRQ_MASK, 32'h1);
        for (int i = 0; i < 8; i++) begin
            data <= vals[i];
            bus(1'b1, ADDR_CTRL1, {25'h0, codes[i], 3'h0, i[0]});
            check(32'(ref_o), 32'(i[0]));
            bus(1'b1, ADDR_CTRL0, {25'h0, 2'b11, codes[i], 2'b01});
            repeat (ACQ_CYCLES) @(posedge clk_i);
            check(32'(hold), 32'h0);
            bus(1'b1, ADDR_CTRL0, {25'h0, 2'b11, codes[i], 2'b11});
            check(32'({on, sel_o}), {26'h0, 3'b111, codes[i]});
            wait_strobe();
            if (divs[i] == 0) begin
                check(32'(cnt), 32'd1500);
                bus(1'b0, ADDR_CTRL0, 32'h0);
                check(32'(rdat[1:0]), 32'h3);
                bus(1'b1, ADDR_CTRL0, 32'h0);
            end else begin
                wait_strobe();
                check(32'(cnt), 32'(divs[i]));
                if (cnt >= 1500) complete_run();
                cnt = 0;
                do begin bus(1'b0, ADDR_CTRL0, 32'h0); cnt++; end while (rdat[1] !== 1'b0 && cnt < 400);
                if (cnt >= 400) begin mismatches++; complete_run(); end
                check(rdat, {25'h0, 2'b11, codes[i], 2'b01});
                check(32'(irq), 32'h1);
                bus(1'b0, ADDR_RES_HIGH, 32'h0);
                check(rdat, {30'h0, vals[i][9:8]});
                bus(1'b0, ADDR_RES_LOW, 32'h0);
                check(rdat, {24'h0, vals[i][7:0]});
                bus(1'b1, ADDR_IRQ_MASK, 32'h0);
                check(32'(irq), 32'h0);
                bus(1'b1, ADDR_IRQ_MASK, 32'h1);
                check(32'(irq), 32'h1);
                bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
                check(32'(irq), 32'h0);
            end
        end
        bus(1'b1, ADDR_CTRL0, 32'h2);
        bus(1'b0, ADDR_CTRL0, 32'h0);
        check(rdat, 32'h0);
        data <= 10'h0fe;
        bus(1'b1, ADDR_CTRL1, {25'h0, CLK_DIV8, 4'h0});
        bus(1'b1, ADDR_CTRL0, 32'h1);
        repeat (ACQ_CYCLES) @(posedge clk_i);
        bus(1'b1, ADDR_CTRL0, 32'h3);
        wait_strobe();
        check(32'(hold), 32'h1);
        bus(1'b1, ADDR_CTRL0, 32'h0);
        bus(1'b0, ADDR_CTRL0, 32'h0);
        check(rdat, 32'h0);
        check(32'(hold), 32'h0);
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        check(rdat, 32'h0);
        bus(1'b1, ADDR_RES_LOW, 32'hff);
        bus(1'b0, ADDR_RES_LOW, 32'h0);
        check(rdat, 32'h01);
        complete_run();
    end
endmodule : acr_adc_regs_tb_top
`default_nettype wire
